// File: src/isrp_pkg.sv
// constants, states and strap decoding for the two-wire target port
package isrp_pkg;

  // bus timing: fastest bit rate the port must follow, against the local clock
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned MAX_BIT_RATE    = 400_000;
  localparam int unsigned CYCLES_PER_BIT  = CLK_HZ / MAX_BIT_RATE;
  // two synchroniser flops plus two of the glitch filter (s3_q, filt_q); the edge stage adds none
  localparam int unsigned LINE_LATENCY    = 4;

  // address straps and target address
  localparam logic [1:0] STRAP_LOW        = 2'h0;
  localparam logic [1:0] STRAP_HIGH       = 2'h1;
  localparam logic [1:0] STRAP_OPEN       = 2'h2;
  localparam logic [6:0] ADDR_BASE        = 7'h50;
  localparam logic [6:0] ADDR_LAST        = 7'h58;
  localparam logic [1:0] STRAP_SETTLE     = 2'h3;

  // byte framing and command byte layout
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam int unsigned RW_BIT          = 0;
  localparam int unsigned CMD_AUTO_BIT    = 6;
  localparam int unsigned LOC_W           = 6;
  localparam int unsigned LOC_COUNT       = 16;

  // line indices inside the synchroniser
  localparam int unsigned LINE_SCL        = 0;
  localparam int unsigned LINE_SDA        = 1;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_IGNORE
  } isrp_state_e;

  // strap pair (high, low) to target address
  function automatic logic [6:0] strap_to_addr(input logic [1:0] hi, input logic [1:0] lo);
    logic [6:0] idx;
    idx = 7'h0;
    case ({hi, lo})
      {STRAP_LOW,  STRAP_LOW }: idx = 7'h0;
      {STRAP_LOW,  STRAP_HIGH}: idx = 7'h1;
      {STRAP_HIGH, STRAP_LOW }: idx = 7'h2;
      {STRAP_HIGH, STRAP_HIGH}: idx = 7'h3;
      {STRAP_LOW,  STRAP_OPEN}: idx = 7'h4;
      {STRAP_OPEN, STRAP_LOW }: idx = 7'h5;
      {STRAP_HIGH, STRAP_OPEN}: idx = 7'h6;
      {STRAP_OPEN, STRAP_HIGH}: idx = 7'h7;
      default:                  idx = 7'h8;
    endcase
    return ADDR_BASE + idx;
  endfunction : strap_to_addr

endpackage : isrp_pkg

// File: src/isrp_line_if.sv
// filtered bus lines and their events, from the synchroniser to the target
`timescale 1ns/1ps
interface isrp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  modport src (output scl, output sda, output scl_rise, output scl_fall, output start,
               output stop);
  modport dst (input scl, input sda, input scl_rise, input scl_fall, input start,
               input stop);
endinterface : isrp_line_if

// File: src/isrp_line_sync.sv
// two-flop synchronisers, glitch filter and edge/condition detection for both lines
`timescale 1ns/1ps
module isrp_line_sync (
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire logic  scl_pin,
  input  wire logic  sda_pin,
  isrp_line_if.src   line
);

  logic [1:0] pin_w;
  logic [1:0] s1_q;
  logic [1:0] s2_q;
  logic [1:0] s3_q;
  logic [1:0] filt_q;
  logic [1:0] prev_q;

  assign pin_w[isrp_pkg::LINE_SCL] = scl_pin;
  assign pin_w[isrp_pkg::LINE_SDA] = sda_pin;

  // idle bus is high on both lines
  for (genvar i = 0; i < 2; i++) begin : g_line
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        s1_q[i]   <= 1'b1;
        s2_q[i]   <= 1'b1;
        s3_q[i]   <= 1'b1;
        filt_q[i] <= 1'b1;
        prev_q[i] <= 1'b1;
      end else begin
        s1_q[i] <= pin_w[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        // a level must be seen on two samples running before it is taken
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
        prev_q[i] <= filt_q[i];
      end
    end
  end

  assign line.scl      = filt_q[isrp_pkg::LINE_SCL];
  assign line.sda      = filt_q[isrp_pkg::LINE_SDA];
  assign line.scl_rise = filt_q[isrp_pkg::LINE_SCL] & ~prev_q[isrp_pkg::LINE_SCL];
  assign line.scl_fall = ~filt_q[isrp_pkg::LINE_SCL] & prev_q[isrp_pkg::LINE_SCL];
  // data change while clock stays high is a bus condition, never data
  assign line.start = filt_q[isrp_pkg::LINE_SCL] & prev_q[isrp_pkg::LINE_SCL]
                    & prev_q[isrp_pkg::LINE_SDA] & ~filt_q[isrp_pkg::LINE_SDA];
  assign line.stop  = filt_q[isrp_pkg::LINE_SCL] & prev_q[isrp_pkg::LINE_SCL]
                    & ~prev_q[isrp_pkg::LINE_SDA] & filt_q[isrp_pkg::LINE_SDA];

  property p_glitch_held;
    @(posedge clk) disable iff (reset)
      (s2_q[isrp_pkg::LINE_SCL] != s3_q[isrp_pkg::LINE_SCL]) |=> $stable(line.scl);
  endproperty
  a_glitch_held: assert property (p_glitch_held)
    else $error("filtered clock moved on a single disagreeing sample");

  property p_start_needs_high_clock;
    @(posedge clk) disable iff (reset)
      line.start |-> line.scl && $past(line.sda) && !line.sda;
  endproperty
  a_start_needs_high_clock: assert property (p_start_needs_high_clock)
    else $error("start flagged without a data fall under high clock");

endmodule : isrp_line_sync

// File: src/isrp_target.sv
// two-wire bus target: address match, command decode, register write and read
`timescale 1ns/1ps
// Functional notes
// - target only: never drives or stretches the serial clock line.
// - works at bit rates up to 400 kbit/s; master must not exceed it.
// - one bit per clock pulse; data change while clock high is a condition.
// - data fall under high clock is START or repeated START; resets bit tracking.
// - data rise under high clock is STOP; ends transaction, back to idle.
// - bus busy from START until STOP, held busy across repeated START.
// - seven-bit target address fixed by strap inputs, not writable.
// - two three-level straps select nine addresses 1010000 to 1011000.
// - first seven bits after START compared with own address; respond on match.
// - eighth bit of first byte: zero master writes, one master reads.
// - each byte followed by ack slot; acker holds data low through clock high.
// - no limit on bytes between START and STOP.
// - addressed receiver acknowledges every byte up to a rejected location, and none from that command on.
// - on master nack the device releases data high for the STOP.
// - byte after write address is command; low six bits select location.
// - single write: addr, ack, command, ack, data msb first, ack and update.
// - command naming a missing location gets nack in its ack slot.
// - command bit 6 enables auto-increment of location after each written byte and each read byte the master acks.
// - read: command in write phase, repeated START with read bit, byte out.
// - auto-increment reads advance to the last location, then wrap to zero.
module isrp_target #(
  parameter int unsigned LOC_COUNT = isrp_pkg::LOC_COUNT
) (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      scl_in,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic [1:0]                address_strap_high,
  input  wire logic [1:0]                address_strap_low,
  output logic                           bus_busy,
  output logic [6:0]                     own_address,
  output logic                           reg_wr_strobe,
  output logic [isrp_pkg::LOC_W-1:0]     reg_wr_addr,
  output logic [7:0]                     reg_wr_data,
  output logic [isrp_pkg::LOC_W-1:0]     reg_rd_addr,
  input  wire logic [7:0]                reg_rd_data
);

  localparam logic [isrp_pkg::LOC_W-1:0] LOC_LAST = isrp_pkg::LOC_W'(LOC_COUNT - 1);
  localparam logic [isrp_pkg::LOC_W-1:0] LOC_ZERO = '0;

  localparam logic [isrp_pkg::LOC_W-1:0] LOC_ONE  = isrp_pkg::LOC_W'(1);

  isrp_line_if line ();

  // frame state and byte tracking
  isrp_pkg::isrp_state_e        state_q;
  isrp_pkg::isrp_state_e        state_d;
  logic [3:0]                   bit_cnt_q;
  logic [7:0]                   rx_q;
  logic [7:0]                   tx_q;
  logic [isrp_pkg::LOC_W-1:0]   loc_q;
  logic [isrp_pkg::LOC_W-1:0]   loc_next;
  logic                         auto_inc_q;
  logic                         loc_ok_q;
  logic                         rd_dir_q;
  logic                         master_ack_q;
  logic                         busy_q;
  logic                         byte_done;
  logic                         data_state;
  logic                         loc_valid;
  logic                         addr_match;

  // strap synchronisers and the address they select
  logic [1:0]                   strap_hi_s1_q;
  logic [1:0]                   strap_hi_s2_q;
  logic [1:0]                   strap_lo_s1_q;
  logic [1:0]                   strap_lo_s2_q;
  logic [6:0]                   own_addr_q;

  // register write port
  logic                         wr_strobe_q;
  logic [isrp_pkg::LOC_W-1:0]   wr_addr_q;
  logic [7:0]                   wr_data_q;

  // the filter costs a few local cycles per line phase, which bounds the bit rate
  isrp_line_sync u_line_sync (
    .clk     (clk),
    .reset   (reset),
    .scl_pin (scl_in),
    .sda_pin (sda_in),
    .line    (line)
  );

  // straps are pins: two flops before the address decode reads them
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_hi_s1_q <= isrp_pkg::STRAP_LOW;
      strap_hi_s2_q <= isrp_pkg::STRAP_LOW;
      strap_lo_s1_q <= isrp_pkg::STRAP_LOW;
      strap_lo_s2_q <= isrp_pkg::STRAP_LOW;
    end else begin
      strap_hi_s1_q <= address_strap_high;
      strap_hi_s2_q <= strap_hi_s1_q;
      strap_lo_s1_q <= address_strap_low;
      strap_lo_s2_q <= strap_lo_s1_q;
    end
  end

  // address comes only from the straps, nothing on the bus can change it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      own_addr_q <= isrp_pkg::ADDR_BASE;
    end else begin
      own_addr_q <= isrp_pkg::strap_to_addr(strap_hi_s2_q, strap_lo_s2_q);
    end
  end

  assign byte_done  = (bit_cnt_q == isrp_pkg::BITS_PER_BYTE);
  assign addr_match = (rx_q[7:1] == own_addr_q);
  assign loc_valid  = (32'(rx_q[isrp_pkg::LOC_W-1:0]) < LOC_COUNT);
  assign loc_next   = (loc_q == LOC_LAST) ? LOC_ZERO : loc_q + LOC_ONE;
  assign data_state = (state_q == isrp_pkg::ST_ADDR)
                    | (state_q == isrp_pkg::ST_CMD)
                    | (state_q == isrp_pkg::ST_WDATA)
                    | (state_q == isrp_pkg::ST_RDATA);

  // conditions take priority over any bit event; moves happen on clock falls
  always_comb begin
    state_d = state_q;
    if (line.stop) begin
      state_d = isrp_pkg::ST_IDLE;
    end else if (line.start) begin
      state_d = isrp_pkg::ST_ADDR;
    end else if (line.scl_fall) begin
      case (state_q)
        isrp_pkg::ST_ADDR: begin
          if (byte_done) begin
            state_d = addr_match ? isrp_pkg::ST_ADDR_ACK : isrp_pkg::ST_IGNORE;
          end
        end
        isrp_pkg::ST_ADDR_ACK: begin
          state_d = rd_dir_q ? isrp_pkg::ST_RDATA : isrp_pkg::ST_CMD;
        end
        isrp_pkg::ST_CMD: begin
          if (byte_done) begin
            state_d = isrp_pkg::ST_CMD_ACK;
          end
        end
        isrp_pkg::ST_CMD_ACK: begin
          state_d = loc_ok_q ? isrp_pkg::ST_WDATA : isrp_pkg::ST_IGNORE;
        end
        isrp_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_d = isrp_pkg::ST_WDATA_ACK;
          end
        end
        isrp_pkg::ST_WDATA_ACK: begin
          state_d = isrp_pkg::ST_WDATA;
        end
        isrp_pkg::ST_RDATA: begin
          if (byte_done) begin
            state_d = isrp_pkg::ST_RDATA_ACK;
          end
        end
        isrp_pkg::ST_RDATA_ACK: begin
          state_d = master_ack_q ? isrp_pkg::ST_RDATA : isrp_pkg::ST_IGNORE;
        end
        isrp_pkg::ST_IDLE: begin
          state_d = isrp_pkg::ST_IDLE;
        end
        isrp_pkg::ST_IGNORE: begin
          state_d = isrp_pkg::ST_IGNORE;
        end
        default: begin
          state_d = isrp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= isrp_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // bit position restarts on every condition and after each byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bit_cnt_q <= 4'h0;
    end else if (line.start || line.stop) begin
      bit_cnt_q <= 4'h0;
    end else if (line.scl_fall && data_state && byte_done) begin
      bit_cnt_q <= 4'h0;
    end else if (line.scl_rise && data_state) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
    end
  end

  // data is taken on the rising clock, msb first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_q <= 8'h00;
    end else if (line.scl_rise && data_state) begin
      rx_q <= {rx_q[6:0], line.sda};
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_dir_q <= 1'b0;
    end else if (line.scl_fall && state_q == isrp_pkg::ST_ADDR && byte_done) begin
      rd_dir_q <= rx_q[isrp_pkg::RW_BIT];
    end
  end

  // command byte: location, auto-increment flag and whether the location exists
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loc_q      <= LOC_ZERO;
      auto_inc_q <= 1'b0;
      loc_ok_q   <= 1'b0;
    end else if (line.scl_fall && state_q == isrp_pkg::ST_CMD && byte_done) begin
      loc_q      <= rx_q[isrp_pkg::LOC_W-1:0];
      auto_inc_q <= rx_q[isrp_pkg::CMD_AUTO_BIT];
      loc_ok_q   <= loc_valid;
    end else if (line.scl_fall && state_q == isrp_pkg::ST_WDATA_ACK && auto_inc_q) begin
      loc_q <= loc_next;
    end else if (line.scl_rise && state_q == isrp_pkg::ST_RDATA_ACK && !line.sda
                 && auto_inc_q) begin
      loc_q <= loc_next;
    end
  end

  // master answer in the read ack slot; low means send another byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      master_ack_q <= 1'b0;
    end else if (line.scl_rise && state_q == isrp_pkg::ST_RDATA_ACK) begin
      master_ack_q <= ~line.sda;
    end
  end

  // read byte is loaded on the fall that opens its first bit, then shifted per fall
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_q <= 8'hFF;
    end else if (line.scl_fall) begin
      if (state_q == isrp_pkg::ST_ADDR_ACK && rd_dir_q) begin
        tx_q <= reg_rd_data;
      end else if (state_q == isrp_pkg::ST_RDATA_ACK && master_ack_q) begin
        tx_q <= reg_rd_data;
      end else if (state_q == isrp_pkg::ST_RDATA && !byte_done) begin
        tx_q <= {tx_q[6:0], 1'b1};
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (line.start) begin
      busy_q <= 1'b1;
    end else if (line.stop) begin
      busy_q <= 1'b0;
    end
  end

  // register update as the data byte's ack slot opens
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_strobe_q <= 1'b0;
      wr_addr_q   <= LOC_ZERO;
      wr_data_q   <= 8'h00;
    end else begin
      wr_strobe_q <= line.scl_fall && state_q == isrp_pkg::ST_WDATA && byte_done;
      if (line.scl_fall && state_q == isrp_pkg::ST_WDATA && byte_done) begin
        wr_addr_q <= loc_q;
        wr_data_q <= rx_q;
      end
    end
  end

  // open drain: the line is only ever pulled low, changes follow a clock fall
  always_comb begin
    sda_oe = 1'b0;
    case (state_q)
      isrp_pkg::ST_ADDR_ACK:  sda_oe = 1'b1;
      isrp_pkg::ST_CMD_ACK:   sda_oe = loc_ok_q;
      isrp_pkg::ST_WDATA_ACK: sda_oe = 1'b1;
      isrp_pkg::ST_RDATA:     sda_oe = ~tx_q[7];
      default:                sda_oe = 1'b0;
    endcase
  end

  // clock line is an input only: no drive, no stretching
  assign sda_out       = 1'b0;
  assign bus_busy      = busy_q;
  assign own_address   = own_addr_q;
  assign reg_wr_strobe = wr_strobe_q;
  assign reg_wr_addr   = wr_addr_q;
  assign reg_wr_data   = wr_data_q;
  assign reg_rd_addr   = loc_q;

  property p_start_restarts;
    @(posedge clk) disable iff (reset)
      line.start |=> state_q == isrp_pkg::ST_ADDR && bit_cnt_q == 4'h0;
  endproperty
  a_start_restarts: assert property (p_start_restarts)
    else $error("start did not restart byte tracking");

  property p_stop_idles;
    @(posedge clk) disable iff (reset)
      line.stop |=> state_q == isrp_pkg::ST_IDLE && !bus_busy;
  endproperty
  a_stop_idles: assert property (p_stop_idles)
    else $error("stop did not return the port to idle");

  property p_busy_held;
    @(posedge clk) disable iff (reset)
      bus_busy && !line.stop |=> bus_busy;
  endproperty
  a_busy_held: assert property (p_busy_held)
    else $error("bus busy dropped without a stop");

  property p_oe_steady;
    @(posedge clk) disable iff (reset)
      $past(line.scl) && !$past(line.start) && !$past(line.stop) |-> $stable(sda_oe);
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("data drive changed while the clock was high");

  property p_bad_loc_nack;
    @(posedge clk) disable iff (reset)
      line.scl_fall && state_q == isrp_pkg::ST_CMD && byte_done && !loc_valid
      |=> state_q == isrp_pkg::ST_CMD_ACK && !sda_oe;
  endproperty
  a_bad_loc_nack: assert property (p_bad_loc_nack)
    else $error("missing location was acknowledged");

  property p_wr_pulse;
    @(posedge clk) disable iff (reset)
      reg_wr_strobe |=> !reg_wr_strobe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("register write strobe held longer than one cycle");

endmodule : isrp_target

// File: sim/isrp_bus_master.sv
// behavioural two-wire bus controller driving clock and data low side
`timescale 1ns/1ps
module isrp_bus_master (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // steps of one local cycle; an 800 ns bit is 6 low then 2 high, so the
  // target's filtered view still sees its own data change under a low clock
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic start();
    sda_low = 1'b0; w(5); scl = 1'b1; w(4); sda_low = 1'b1; w(4); scl = 1'b0; w(2);
  endtask : start
  task automatic stop();
    sda_low = 1'b1; w(5); scl = 1'b1; w(4); sda_low = 1'b0; w(6);
  endtask : stop
  task automatic bit_out(input logic b);
    sda_low = ~b; w(5); scl = 1'b1; w(2); scl = 1'b0; w(1);
  endtask : bit_out
  task automatic bit_in(output logic b);
    sda_low = 1'b0; w(5); scl = 1'b1; w(1); b = sda_line; w(1); scl = 1'b0; w(1);
  endtask : bit_in
  task automatic wr(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask : wr
  task automatic rd(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(~ack);
  endtask : rd
endmodule : isrp_bus_master

// File: sim/isrp_target_tb.sv
// self-checking bench for the two-wire target port
`timescale 1ns/1ps
module isrp_target_tb;
  logic clk = 1'b0, reset = 1'b1, scl, m_low, sda_out, sda_oe, busy, wstb, a;
  logic [1:0] sh = isrp_pkg::STRAP_HIGH, sl = isrp_pkg::STRAP_LOW;
  logic [6:0] own;
  logic [5:0] waddr, raddr;
  logic [7:0] wdata, wa, wd, d;
  int fail_count = 0, checks_done = 0, cyc = 0;
  wire sda_w = ~(m_low | (sda_oe & ~sda_out));
  always #50 clk = ~clk;
  isrp_bus_master m (.clk(clk), .sda_line(sda_w), .scl(scl), .sda_low(m_low));
  isrp_target dut (.clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .address_strap_high(sh), .address_strap_low(sl),
    .bus_busy(busy), .own_address(own), .reg_wr_strobe(wstb), .reg_wr_addr(waddr),
    .reg_wr_data(wdata), .reg_rd_addr(raddr), .reg_rd_data({2'h0, raddr} ^ 8'hC3));
  always @(posedge clk) if (wstb) begin wa <= {2'h0, waddr}; wd <= wdata; end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (e !== g) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  task automatic t_straps();
    logic [1:0] hs [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2, 2'h2};
    logic [1:0] ls [9] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h2};
    for (int i = 0; i < 9; i++) begin
      @(negedge clk); sh = hs[i]; sl = ls[i]; repeat (6) @(negedge clk);
      chk("addr", 8'(8'h50 + i), {1'b0, own});
    end
    @(negedge clk); sh = isrp_pkg::STRAP_HIGH; sl = isrp_pkg::STRAP_LOW; repeat (6) @(negedge clk);
    $display("straps done");
  endtask : t_straps
  task automatic t_write();
    m.start(); m.wr(8'hA4, a); chk("ack a", 1, a);
    m.wr(8'h0F, a); chk("ack c", 1, a);
    m.wr(8'h5A, a); chk("ack d", 1, a); m.stop();
    chk("wloc", 8'h0F, wa); chk("wdat", 8'h5A, wd); chk("idle", 0, busy);
    m.start(); m.wr(8'hA4, a); m.wr(8'h10, a); chk("rej", 0, a); m.stop();
    m.start(); m.wr(8'hA6, a); chk("miss", 0, a); m.stop();
    $display("write done");
  endtask : t_write
  task automatic t_read();
    m.start(); m.wr(8'hA4, a); m.wr(8'h47, a); m.start(); chk("busy", 1, busy);
    m.wr(8'hA5, a); chk("ack r", 1, a); m.rd(d, 1'b1); chk("rd0", 8'hC4, d);
    m.rd(d, 1'b0); chk("rd1", 8'hCB, d); m.stop(); chk("idle", 0, busy);
    $display("read done");
  endtask : t_read
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin fail_count++; give_verdict(); end
  end
  initial begin
    repeat (6) @(negedge clk);
    reset = 1'b0;
    repeat (4) @(negedge clk);
    t_straps();
    t_write();
    t_read();
    give_verdict();
  end
endmodule : isrp_target_tb
